// [common/lbbi_pkg.sv]
// Shared constants and types for the local-to-backplane bridge
package lbbi_pkg;
  localparam int CLK_NS = 40;
  localparam int MASTER_NS = 100;
  localparam int PHASE_CYC = (MASTER_NS + CLK_NS - 1) / CLK_NS;
  localparam int TIMEOUT_NS = 15000;
  localparam int TIMEOUT_CYC = (TIMEOUT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] PH_ACK = 2'h1;
  localparam logic [15:0] STATUS_ADDR = 16'hfc24;
  localparam int ST_BUS_ERR = 0;
  localparam int ST_TICK = 1;
  localparam int ST_INTVL = 2;
  localparam int ST_PWR_FAIL = 4;
  localparam int ST_PRINT_SEL = 5;
  localparam int ST_IRQ_EN = 6;
  localparam int ST_INIT = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [15:0] VEC_BUS_ERR = 16'h0002;
  localparam logic [15:0] VEC_PWR_FAIL = 16'h0006;
  localparam logic [15:0] VEC_DMA = 16'h000a;
  localparam logic [15:0] VEC_TX_RDY = 16'h000e;
  localparam logic [15:0] VEC_RX_DATA = 16'h0012;
  localparam logic [15:0] VEC_PRINT = 16'h0016;
  localparam logic [15:0] VEC_TICK = 16'h001a;
  localparam logic [15:0] VEC_INTVL = 16'h001e;
  localparam int PIN_W = 7;
  localparam int P_RPLY = 0;
  localparam int P_HALT = 1;
  localparam int P_INIT = 2;
  localparam int P_IRQ = 3;
  localparam int P_DMR = 4;
  localparam int P_DCOK = 5;
  localparam int P_POK = 6;
  // Supply-good pins idle high, so their sync stages reset high
  localparam logic [PIN_W-1:0] PIN_IDLE = 7'h60;

  typedef enum logic [1:0] {
    ACK_IDLE = 2'b00,
    ACK_SYNC = 2'b01,
    ACK_DIN = 2'b10,
    ACK_DONE = 2'b11
  } lbbi_ack_e;

  // One bit per backplane control pin; high means pin pulled low
  typedef struct packed {
    logic bsync;
    logic bdin;
    logic bdout;
    logic bwtbt;
    logic bbs7;
    logic biako;
    logic bdmgo;
  } lbbi_bp_ctl_s;

  // On-board requests, highest priority in the top bit
  typedef struct packed {
    logic bus_err;
    logic pwr_fail;
    logic dma;
    logic tx_rdy;
    logic rx_data;
    logic print;
    logic tick;
    logic intvl;
  } lbbi_onb_s;
endpackage : lbbi_pkg

// [logic/lbbi_bridge.sv]
// Local bus to backplane bridge with interrupt, DMA and timeout glue
// Functional notes
// - Enabled level-0 request starts acknowledge sequence
// - int_ack and sync rise phase 2, held
// - Only level-0 request can start interrupts
// - Acknowledge clears the interrupt enable bit
// - On-board sources outrank all backplane sources
// - Fixed on-board priorities and vectors
// - Power fail sets flag, interrupts at 6
// - Power return resets, boots monitor ROM
// - Power return restores timer and baud rates
// - Sync over 15 us sets error, replies
// - Bus error interrupts through vector 2
// - Processor word address doubled onto backplane
// - DMA byte addresses pass unshifted
// - Local strobes drive backplane; reply returns
// - Halt stops run; init resets processor
// - Processor I/O page address asserts bbs7
// - Bus timing from 10 MHz master rate
// - Backplane request ORed into level 0
// - On-board requester blocks acknowledge chain
// - Backplane DMA request ORed with on-board
// - On-board DMA requester blocks grant chain
// - Bus error flag cleared by writing one
// - Disabled error, power, tick and interval interrupts stay latched until enabled
// - Status byte at word address fc24
module lbbi_bridge (
  input wire logic clk,
  input wire logic resetn,
  input wire logic cpu_sync,
  input wire logic cpu_din,
  input wire logic cpu_dout,
  input wire logic cpu_wtbt,
  input wire logic cpu_addr_valid,
  input wire logic [15:0] local_addr_data,
  input wire logic dma_master,
  input wire logic dma_grant_chain,
  input wire logic onb_dma_req,
  input wire logic onb_dma_irq,
  input wire logic tx_rdy_irq,
  input wire logic rx_data_irq,
  input wire logic print_irq,
  input wire logic tick_event,
  input wire logic intvl_event,
  input wire logic init_strap,
  input wire logic brply_n,
  input wire logic bhalt_n,
  input wire logic binit_n,
  input wire logic birq_n,
  input wire logic bdmr_n,
  input wire logic bdcok,
  input wire logic bpok,
  input wire logic [21:0] bdal_in,
  output logic [21:0] bdal_out,
  output logic bdal_oe,
  output lbbi_pkg::lbbi_bp_ctl_s bp_ctl_out,
  output lbbi_pkg::lbbi_bp_ctl_s bp_ctl_oe,
  output logic local_sync,
  output logic read_strobe,
  output logic local_reply,
  output logic [15:0] local_data_in,
  output logic int_ack,
  output logic irq_level0,
  output logic dma_request,
  output logic run_enable,
  output logic cpu_reset,
  output logic cpu_busy,
  output logic vec_valid,
  output logic [15:0] vec,
  output logic print_sel,
  output logic rate_restore,
  output logic boot_monitor
);
  import lbbi_pkg::*;

  function automatic logic [15:0] prio_vec(input lbbi_onb_s r);
    logic [15:0] v;
    v = VEC_INTVL;
    if (r.tick) v = VEC_TICK;
    if (r.print) v = VEC_PRINT;
    if (r.rx_data) v = VEC_RX_DATA;
    if (r.tx_rdy) v = VEC_TX_RDY;
    if (r.dma) v = VEC_DMA;
    if (r.pwr_fail) v = VEC_PWR_FAIL;
    if (r.bus_err) v = VEC_BUS_ERR;
    return v;
  endfunction : prio_vec

  // Pin synchronisers; a change counts once stages two and three agree
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] s1_reg, s2_reg, s3_reg, filt_reg, filt_next;
  logic [21:0] d1_reg, d2_reg, d3_reg;
  assign pin_raw = {bpok, bdcok, ~bdmr_n, ~birq_n, ~binit_n, ~bhalt_n,
                    ~brply_n};

  always_comb begin
    filt_next = (s2_reg & s3_reg) | (filt_reg & (s2_reg | s3_reg));
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      // Idle levels here avoid a false power return after reset
      s1_reg <= PIN_IDLE;
      s2_reg <= PIN_IDLE;
      s3_reg <= PIN_IDLE;
      filt_reg <= PIN_IDLE;
      d1_reg <= '0;
      d2_reg <= '0;
      d3_reg <= '0;
    end else begin
      s1_reg <= pin_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_reg <= filt_next;
      d1_reg <= bdal_in;
      d2_reg <= d1_reg;
      d3_reg <= d2_reg;
    end
  end

  // Master-rate phase generator; 25 MHz cannot divide to 10 MHz exactly
  logic [1:0] ph_cnt_reg, ph_cnt_next, phase_reg, phase_next;
  logic ph_tick;
  always_comb begin
    ph_tick = (ph_cnt_reg == 2'(PHASE_CYC - 1));
    ph_cnt_next = ph_tick ? 2'h0 : ph_cnt_reg + 2'h1;
    phase_next = ph_tick ? phase_reg + 2'h1 : phase_reg;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ph_cnt_reg <= 2'h0;
      phase_reg <= 2'h0;
    end else begin
      ph_cnt_reg <= ph_cnt_next;
      phase_reg <= phase_next;
    end
  end

  // Status byte, sync timeout and acknowledge sequencer
  lbbi_ack_e ack_reg, ack_next;
  logic [7:0] st_reg, st_next;
  logic [8:0] to_cnt_reg, to_cnt_next;
  logic to_fired_reg, to_fired_next;
  logic sel_reg, sel_next, wr_done_reg, wr_done_next;
  logic ack_local_reg, ack_local_next;
  logic pok_d_reg, vec_valid_next;
  logic [15:0] vec_next;
  logic sync_eff, din_eff, to_fire, st_wr, pwr_down, pwr_up, onb_any;
  logic onb_reply, bp_reply, ack_reply;
  lbbi_onb_s onb;

  always_comb begin
    onb = '{bus_err: st_reg[ST_BUS_ERR], pwr_fail: st_reg[ST_PWR_FAIL],
            dma: onb_dma_irq, tx_rdy: tx_rdy_irq, rx_data: rx_data_irq,
            print: print_irq, tick: st_reg[ST_TICK],
            intvl: st_reg[ST_INTVL]};
    onb_any = |onb;
    sync_eff = cpu_sync | (ack_reg != ACK_IDLE && ack_reg != ACK_DONE);
    din_eff = cpu_din | (ack_reg == ACK_DIN);
    pwr_down = pok_d_reg & ~filt_reg[P_POK];
    pwr_up = ~pok_d_reg & filt_reg[P_POK] & filt_reg[P_DCOK];
    // Counter clears whenever sync is low, so each cycle is timed alone
    to_cnt_next = to_cnt_reg;
    to_fired_next = to_fired_reg;
    to_fire = 1'b0;
    if (!sync_eff) begin
      to_cnt_next = 9'h000;
      to_fired_next = 1'b0;
    end else if (!to_fired_reg) begin
      if (to_cnt_reg == 9'(TIMEOUT_CYC - 1)) begin
        to_fire = 1'b1;
        to_fired_next = 1'b1;
      end else begin
        to_cnt_next = to_cnt_reg + 9'h001;
      end
    end
    sel_next = sel_reg;
    if (cpu_addr_valid) begin
      sel_next = (local_addr_data == STATUS_ADDR) && !dma_master;
    end else if (!cpu_sync) begin
      sel_next = 1'b0;
    end
    st_wr = sel_reg & cpu_dout & ~wr_done_reg;
    wr_done_next = sel_reg & cpu_dout;
    st_next = st_reg;
    if (st_wr) begin
      // A store loads only the print-select and enable bits; flag bits clear only on a written one
      st_next[ST_BUS_ERR] = st_reg[ST_BUS_ERR] &
                            ~local_addr_data[ST_BUS_ERR];
      st_next[ST_TICK] = st_reg[ST_TICK] & ~local_addr_data[ST_TICK];
      st_next[ST_INTVL] = st_reg[ST_INTVL] & ~local_addr_data[ST_INTVL];
      st_next[ST_PWR_FAIL] = st_reg[ST_PWR_FAIL] &
                             ~local_addr_data[ST_PWR_FAIL];
      st_next[ST_PRINT_SEL] = local_addr_data[ST_PRINT_SEL];
      st_next[ST_IRQ_EN] = local_addr_data[ST_IRQ_EN];
    end
    // Sets follow the clear so a same-cycle event is kept
    if (to_fire || (st_wr && local_addr_data[ST_INIT])) begin
      st_next[ST_BUS_ERR] = 1'b1;
    end
    if (pwr_down) st_next[ST_PWR_FAIL] = 1'b1;
    if (tick_event) st_next[ST_TICK] = 1'b1;
    if (intvl_event) st_next[ST_INTVL] = 1'b1;
    onb_reply = sel_reg & (cpu_din | cpu_dout);
    bp_reply = filt_reg[P_RPLY];
    ack_reply = ack_local_reg | bp_reply;
    ack_next = ack_reg;
    ack_local_next = ack_local_reg;
    vec_valid_next = 1'b0;
    vec_next = vec;
    unique case (ack_reg)
      ACK_IDLE: begin
        // Level 0 only; enable gates taking, status flags stay latched
        if (irq_level0 && st_reg[ST_IRQ_EN] && !cpu_sync &&
            !cpu_addr_valid && !dma_grant_chain && ph_tick &&
            phase_reg == PH_ACK) begin
          ack_next = ACK_SYNC;
          ack_local_next = onb_any;
          st_next[ST_IRQ_EN] = 1'b0;
        end
      end
      ACK_SYNC: begin
        if (ph_tick) ack_next = ACK_DIN;
      end
      ACK_DIN: begin
        if (ack_reply) begin
          vec_next = ack_local_reg ? prio_vec(onb) : d3_reg[15:0];
          vec_valid_next = 1'b1;
          ack_next = ACK_DONE;
        end else if (to_fired_reg) begin
          ack_next = ACK_DONE;
        end
      end
      ACK_DONE: begin
        if (!bp_reply) begin
          ack_next = ACK_IDLE;
          ack_local_next = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_reg <= ACK_IDLE;
      st_reg <= STATUS_RESET;
      to_cnt_reg <= 9'h000;
      to_fired_reg <= 1'b0;
      sel_reg <= 1'b0;
      wr_done_reg <= 1'b0;
      ack_local_reg <= 1'b0;
      pok_d_reg <= 1'b1;
      vec_valid <= 1'b0;
      vec <= 16'h0000;
    end else begin
      ack_reg <= ack_next;
      st_reg <= st_next;
      to_cnt_reg <= to_cnt_next;
      to_fired_reg <= to_fired_next;
      sel_reg <= sel_next;
      wr_done_reg <= wr_done_next;
      ack_local_reg <= ack_local_next;
      pok_d_reg <= filt_reg[P_POK];
      vec_valid <= vec_valid_next;
      vec <= vec_next;
    end
  end

  // Output stage; every port leaves from a flop, one cycle behind
  logic [21:0] bp_addr;
  logic [15:0] rd_data;
  logic local_only;
  lbbi_bp_ctl_s ctl_next;
  always_comb begin
    bp_addr = dma_master ? {6'h00, local_addr_data}
                         : {5'h00, local_addr_data, 1'b0};
    local_only = sel_reg | ack_local_reg;
    ctl_next.bsync = sync_eff & ~local_only;
    ctl_next.bdin = din_eff & ~local_only;
    ctl_next.bdout = cpu_dout & ~sel_reg;
    ctl_next.bwtbt = cpu_wtbt & ~sel_reg;
    ctl_next.bbs7 = cpu_addr_valid & (&bp_addr[16:13]);
    ctl_next.biako = int_ack & ~onb_any;
    ctl_next.bdmgo = dma_grant_chain & ~onb_dma_req;
    rd_data = d3_reg[15:0];
    if (sel_reg) begin
      rd_data = {8'h00, init_strap, st_reg[ST_IRQ_EN], 1'b0,
                 st_reg[ST_PWR_FAIL], 1'b0, st_reg[ST_INTVL:ST_BUS_ERR]};
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bdal_out <= '0;
      bdal_oe <= 1'b0;
      bp_ctl_out <= '0;
      bp_ctl_oe <= '0;
      local_sync <= 1'b0;
      read_strobe <= 1'b0;
      local_reply <= 1'b0;
      local_data_in <= 16'h0000;
      int_ack <= 1'b0;
      irq_level0 <= 1'b0;
      dma_request <= 1'b0;
      run_enable <= 1'b0;
      cpu_reset <= 1'b1;
      cpu_busy <= 1'b0;
      print_sel <= 1'b0;
      rate_restore <= 1'b0;
      boot_monitor <= 1'b0;
    end else begin
      bdal_out <= cpu_addr_valid ? bp_addr : {6'h00, local_addr_data};
      bdal_oe <= (cpu_addr_valid | cpu_dout) & ~sel_reg;
      bp_ctl_out <= '0;
      bp_ctl_oe <= ctl_next;
      local_sync <= sync_eff;
      read_strobe <= din_eff;
      local_reply <= onb_reply | (bp_reply & ~local_only) |
                     (to_fired_reg & sync_eff) |
                     (ack_reg == ACK_DIN && ack_local_reg);
      local_data_in <= rd_data;
      // Same state as local_sync, so both rise on one edge
      int_ack <= (ack_reg == ACK_SYNC) || (ack_reg == ACK_DIN);
      irq_level0 <= onb_any | filt_reg[P_IRQ];
      dma_request <= onb_dma_req | filt_reg[P_DMR];
      run_enable <= ~filt_reg[P_HALT];
      cpu_reset <= filt_reg[P_INIT] | pwr_up;
      cpu_busy <= ack_next != ACK_IDLE;
      print_sel <= st_reg[ST_PRINT_SEL];
      rate_restore <= pwr_up;
      boot_monitor <= pwr_up;
    end
  end
endmodule : lbbi_bridge

// [verif/lbbi_bp_model.sv]
// Backplane slave and interrupter model facing the bridge
module lbbi_bp_model #(
  parameter logic [15:0] RD_DATA = 16'h5a3c,
  parameter logic [15:0] BP_VEC = 16'h0104
) (
  input wire logic clk,
  input wire lbbi_pkg::lbbi_bp_ctl_s bp_ctl_oe,
  input wire logic [3:0] dly,
  input wire logic mute,
  output logic brply_n,
  output logic [21:0] bdal_in
);
  import lbbi_pkg::*;
  logic [3:0] cnt;
  initial begin
    brply_n = 1'b1;
    bdal_in = 22'h0;
    cnt = 4'h0;
  end
  always @(posedge clk) begin
    if (bp_ctl_oe.bsync && (bp_ctl_oe.bdin || bp_ctl_oe.bdout) && !mute) begin
      // Data settles before the reply
      bdal_in <= {6'h0, bp_ctl_oe.biako ? BP_VEC : RD_DATA};
      if (cnt < dly) cnt <= cnt + 4'h1;
      brply_n <= (cnt < dly);
    end else begin
      cnt <= 4'h0;
      brply_n <= 1'b1;
      // Released lines float, so every bit inverts each cycle and the last data returns every other cycle
      bdal_in <= ~bdal_in;
    end
  end
endmodule : lbbi_bp_model

// [verif/lbbi_chk.sv]
// Port assertions for the bridge
module lbbi_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic dma_grant_chain,
  input wire logic onb_dma_req,
  input wire logic bdmr_n,
  input wire logic bhalt_n,
  input wire logic binit_n,
  input wire lbbi_pkg::lbbi_bp_ctl_s bp_ctl_oe,
  input wire logic local_sync,
  input wire logic read_strobe,
  input wire logic local_reply,
  input wire logic int_ack,
  input wire logic dma_request,
  input wire logic run_enable,
  input wire logic cpu_reset
);
  import lbbi_pkg::*;
  // Slack covers the registered fire and reply stages behind the timer
  localparam int TO_MAX = TIMEOUT_CYC + 8;
  int wait_reg;
  int wait_next;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  always_comb begin
    wait_next = (local_sync && !local_reply) ? wait_reg + 1 : 0;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) wait_reg <= 0;
    else wait_reg <= wait_next;
  end
  sequence s_sync_then_din;
    local_sync ##[1:4] read_strobe;
  endsequence
  property p_ack_seq;
    $rose(int_ack) |-> s_sync_then_din;
  endproperty
  a_ack_seq: assert property (p_ack_seq)
    else $error("ack without sync then strobe");
  property p_ack_hold;
    $fell(int_ack) |-> local_reply || $past(local_reply);
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("ack dropped before reply");
  property p_biako;
    bp_ctl_oe.biako |-> int_ack || $past(int_ack);
  endproperty
  a_biako: assert property (p_biako)
    else $error("chain out without ack");
  property p_grant;
    $past(resetn) |-> bp_ctl_oe.bdmgo == $past(dma_grant_chain && !onb_dma_req);
  endproperty
  a_grant: assert property (p_grant)
    else $error("grant chain wrong");
  property p_bdmr;
    (!bdmr_n)[*6] |-> dma_request;
  endproperty
  a_bdmr: assert property (p_bdmr)
    else $error("dma request missing");
  property p_halt;
    (!bhalt_n)[*6] |-> !run_enable;
  endproperty
  a_halt: assert property (p_halt)
    else $error("run while halted");
  property p_init;
    (!binit_n)[*6] |-> cpu_reset;
  endproperty
  a_init: assert property (p_init)
    else $error("no reset on init");
  property p_timeout;
    wait_reg <= TO_MAX;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("sync not terminated");
endmodule : lbbi_chk

// [verif/tb_local_bus_backplane_bridge_irq.sv]
// Self-checking bench for the backplane bridge
module tb_local_bus_backplane_bridge_irq;
  timeunit 1ns;
  timeprecision 1ps;
  import lbbi_pkg::*;
  typedef struct packed {
    logic [5:0] ins;
    logic [4:0] outs;
  } lbbi_row_s;
  localparam lbbi_row_s ROWS [8] = '{'{6'h0f, 5'h04}, '{6'h2f, 5'h14},
    '{6'h3f, 5'h0c}, '{6'h07, 5'h0c}, '{6'h0b, 5'h00}, '{6'h0d, 5'h06},
    '{6'h0e, 5'h05}, '{6'h0f, 5'h04}};
  localparam logic [15:0] VECS [6] = '{VEC_DMA, VEC_TX_RDY, VEC_RX_DATA,
    VEC_PRINT, VEC_TICK, VEC_INTVL};
  logic clk, resetn, cpu_sync, cpu_din, cpu_dout, cpu_addr_valid;
  logic dma_master, dma_grant_chain, onb_dma_req, onb_dma_irq, tx_rdy_irq;
  logic rx_data_irq, print_irq, tick_event, intvl_event, brply_n, bhalt_n;
  logic binit_n, birq_n, bdmr_n, bpok, mute, local_reply, int_ack;
  logic irq_level0, dma_request, run_enable, cpu_reset, cpu_busy;
  logic vec_valid, rate_restore, boot_monitor;
  logic cpu_wtbt, bdal_oe, print_sel;
  logic [3:0] dly;
  logic [15:0] local_addr_data, local_data_in, vec, rd;
  logic [21:0] bdal_in, bdal_out;
  lbbi_bp_ctl_s bp_ctl_oe, bp_ctl_out;
  int err_count, checks, n, biako_n, rr_n, bm_n, b0;
  lbbi_bridge lbbi_bridge_inst (.clk(clk), .resetn(resetn),
    .cpu_sync(cpu_sync), .cpu_din(cpu_din), .cpu_dout(cpu_dout),
    .cpu_wtbt(cpu_wtbt), .cpu_addr_valid(cpu_addr_valid),
    .local_addr_data(local_addr_data), .dma_master(dma_master),
    .dma_grant_chain(dma_grant_chain), .onb_dma_req(onb_dma_req),
    .onb_dma_irq(onb_dma_irq), .tx_rdy_irq(tx_rdy_irq),
    .rx_data_irq(rx_data_irq), .print_irq(print_irq),
    .tick_event(tick_event), .intvl_event(intvl_event), .init_strap(1'b1),
    .brply_n(brply_n), .bhalt_n(bhalt_n), .binit_n(binit_n),
    .birq_n(birq_n), .bdmr_n(bdmr_n), .bdcok(1'b1), .bpok(bpok),
    .bdal_in(bdal_in), .bdal_out(bdal_out), .bdal_oe(bdal_oe),
    .bp_ctl_out(bp_ctl_out),
    .bp_ctl_oe(bp_ctl_oe), .local_sync(), .read_strobe(),
    .local_reply(local_reply), .local_data_in(local_data_in),
    .int_ack(int_ack), .irq_level0(irq_level0), .dma_request(dma_request),
    .run_enable(run_enable), .cpu_reset(cpu_reset), .cpu_busy(cpu_busy),
    .vec_valid(vec_valid), .vec(vec), .print_sel(print_sel),
    .rate_restore(rate_restore), .boot_monitor(boot_monitor));
  lbbi_bp_model lbbi_bp_model_inst (.clk(clk), .bp_ctl_oe(bp_ctl_oe),
    .dly(dly), .mute(mute), .brply_n(brply_n), .bdal_in(bdal_in));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    biako_n <= biako_n + int'(bp_ctl_oe.biako === 1'b1);
    rr_n <= rr_n + int'(rate_restore === 1'b1);
    bm_n <= bm_n + int'(boot_monitor === 1'b1);
  end
  task automatic chk1(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask : chk1
  task automatic chkw(input string nm, input logic [21:0] e,
                      input logic [21:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chkw
  task automatic bus(input logic [15:0] a, input logic wr,
                     input logic [15:0] wd);
    // A lingering reply from the last cycle must drop first
    do @(posedge clk); while (cpu_busy !== 1'b0 || local_reply !== 1'b0);
    cpu_addr_valid <= 1'b1;
    local_addr_data <= a;
    @(posedge clk);
    cpu_addr_valid <= 1'b0;
    cpu_sync <= 1'b1;
    cpu_din <= !wr;
    cpu_dout <= wr;
    cpu_wtbt <= wr;
    local_addr_data <= wd;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (local_reply !== 1'b1 && n < 600);
    rd = local_data_in;
    chk1("reply", 1'b1, local_reply);
    if (a != STATUS_ADDR && !mute) begin
      chk1("bsync", 1'b1, bp_ctl_oe.bsync);
      chk1("bdout", wr, bp_ctl_oe.bdout);
      chk1("bdin", !wr, bp_ctl_oe.bdin);
      chk1("bwtbt", wr, bp_ctl_oe.bwtbt);
    end
    cpu_sync <= 1'b0;
    cpu_din <= 1'b0;
    cpu_dout <= 1'b0;
    cpu_wtbt <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic ack(input logic [15:0] e);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (vec_valid !== 1'b1 && n < 300);
    chk1("vec_valid", 1'b1, vec_valid);
    chkw("vec", {6'h0, e}, {6'h0, vec});
  endtask : ack
  task automatic summarize();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize
  initial begin
    {resetn, cpu_sync, cpu_din, cpu_dout, cpu_addr_valid, dma_master} = '0;
    {dma_grant_chain, onb_dma_req, onb_dma_irq, tx_rdy_irq} = '0;
    {rx_data_irq, print_irq, tick_event, intvl_event, mute, cpu_wtbt} = '0;
    {bhalt_n, binit_n, birq_n, bdmr_n, bpok} = '1;
    local_addr_data = 16'h0000;
    dly = 4'h3;
    {err_count, checks, biako_n, rr_n, bm_n} = {5{32'sd0}};
    repeat (12) @(posedge clk);
    chk1("cpu_reset", 1'b1, cpu_reset);
    resetn <= 1'b1;
    repeat (8) @(posedge clk);
    foreach (ROWS[i]) begin
      {dma_grant_chain, onb_dma_req, bdmr_n, bhalt_n, birq_n, binit_n}
        <= ROWS[i].ins;
      repeat (8) @(posedge clk);
      chkw("pins", {17'h0, ROWS[i].outs}, {17'h0, bp_ctl_oe.bdmgo,
        dma_request, run_enable, irq_level0, cpu_reset});
    end
    local_addr_data <= 16'hf123;
    cpu_addr_valid <= 1'b1;
    repeat (3) @(posedge clk);
    chkw("addr", 22'h01e246, bdal_out);
    chk1("bbs7", 1'b1, bp_ctl_oe.bbs7);
    chk1("bdal_oe", 1'b1, bdal_oe);
    chkw("ctl_out", 22'h0, {15'h0, bp_ctl_out});
    dma_master <= 1'b1;
    repeat (3) @(posedge clk);
    chkw("addr", 22'h00f123, bdal_out);
    chk1("bbs7", 1'b0, bp_ctl_oe.bbs7);
    cpu_addr_valid <= 1'b0;
    dma_master <= 1'b0;
    bus(16'h1000, 1'b0, 16'h0000);
    chkw("bp_read", 22'h005a3c, {6'h0, rd});
    dly <= 4'h9;
    bus(16'h1002, 1'b1, 16'h1234);
    // Backplane request stays up: each of the six on-board sources from dma to intvl must win
    birq_n <= 1'b0;
    b0 = biako_n;
    for (int k = 0; k < 6; k++) begin
      bus(STATUS_ADDR, 1'b1, 16'h0006);
      {onb_dma_irq, tx_rdy_irq, rx_data_irq, print_irq, tick_event,
        intvl_event} <= 6'h20 >> k;
      @(posedge clk);
      {tick_event, intvl_event} <= 2'b00;
      // Tick and interval latch while disabled, the rest are held, so each is pending at enable
      bus(STATUS_ADDR, 1'b1, 16'h0040);
      ack(VECS[k]);
      {onb_dma_irq, tx_rdy_irq, rx_data_irq, print_irq} <= 4'h0;
    end
    chk1("biako", 1'b1, biako_n == b0);
    dly <= 4'hc;
    bus(STATUS_ADDR, 1'b1, 16'h0044);
    ack(16'h0104);
    chk1("biako", 1'b1, biako_n > b0);
    birq_n <= 1'b1;
    mute <= 1'b1;
    bus(16'h2000, 1'b0, 16'h0000);
    chk1("timeout", 1'b1, n >= TIMEOUT_CYC - 4 && n <= TIMEOUT_CYC + 8);
    mute <= 1'b0;
    bus(STATUS_ADDR, 1'b0, 16'h0000);
    chkw("status", 22'h000081, {6'h0, rd});
    bus(STATUS_ADDR, 1'b1, 16'h0040);
    ack(VEC_BUS_ERR);
    bus(STATUS_ADDR, 1'b1, 16'h0001);
    bus(STATUS_ADDR, 1'b0, 16'h0000);
    chkw("status", 22'h000080, {6'h0, rd});
    bus(STATUS_ADDR, 1'b1, 16'h0020);
    chk1("print_sel", 1'b1, print_sel);
    bpok <= 1'b0;
    repeat (8) @(posedge clk);
    bus(STATUS_ADDR, 1'b0, 16'h0000);
    chkw("status", 22'h000090, {6'h0, rd});
    bus(STATUS_ADDR, 1'b1, 16'h0040);
    ack(VEC_PWR_FAIL);
    bpok <= 1'b1;
    repeat (12) @(posedge clk);
    chk1("restore", 1'b1, rr_n == 1);
    chk1("boot", 1'b1, bm_n == 1);
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    $display("BAD watchdog expected finish seen hang");
    summarize();
  end
endmodule : tb_local_bus_backplane_bridge_irq

bind lbbi_bridge lbbi_chk lbbi_chk_inst (.clk(clk), .resetn(resetn),
  .dma_grant_chain(dma_grant_chain), .onb_dma_req(onb_dma_req),
  .bdmr_n(bdmr_n), .bhalt_n(bhalt_n), .binit_n(binit_n),
  .bp_ctl_oe(bp_ctl_oe), .local_sync(local_sync),
  .read_strobe(read_strobe), .local_reply(local_reply), .int_ack(int_ack),
  .dma_request(dma_request), .run_enable(run_enable),
  .cpu_reset(cpu_reset));
